// ### cict_pkg.sv
// Package for the instruction cycle timing block: operation codes,
// request carrier, cycle figures and the output clock hold count.
// Assumes one clock domain; all figures but the two ns times are counted in input clocks.
package cict_pkg;

  // Instruction groups timed by this block
  typedef enum logic [2:0] {
    CICT_ADC_IMM_ACC = 3'h0, // Add with carry, immediate to accumulator
    CICT_CMP_IMM_ACC = 3'h1, // compare_op, immediate with accumulator
    CICT_AND_RM_REG = 3'h2, // Conjunction, reg/mem with register
    CICT_CALL_FAR_DIR = 3'h3, // Direct far call
    CICT_CALL_NEAR_DIR = 3'h4, // Direct near call
    CICT_CALL_FAR_IND = 3'h5, // Indirect far call
    CICT_CMP_RM_REG = 3'h6, // compare_op, reg/mem with register
    CICT_ADC_IMM_RM = 3'h7 // Add with carry, immediate to reg/mem
  } cict_op_t;

  // One instruction request
  typedef struct packed {
    cict_op_t op; // Instruction group
    logic second_form; // Memory or word form of a paired figure
    logic word_op; // Word sized operand
  } cict_req_t;

  // Cycle figures in input clocks
  localparam logic [5:0] CICT_ACC_BYTE = 6'h03;
  localparam logic [5:0] CICT_ACC_WORD = 6'h04;
  localparam logic [5:0] CICT_RM_REG = 6'h03;
  localparam logic [5:0] CICT_RM_MEM = 6'h0A;
  localparam logic [5:0] CICT_IMM_REG = 6'h04;
  localparam logic [5:0] CICT_IMM_MEM = 6'h10;
  localparam logic [5:0] CICT_FAR_DIR_W16 = 6'h17;
  localparam logic [5:0] CICT_FAR_DIR_W8 = 6'h1F;
  localparam logic [5:0] CICT_NEAR_DIR_W16 = 6'h0F;
  localparam logic [5:0] CICT_NEAR_DIR_W8 = 6'h13;
  localparam logic [5:0] CICT_FAR_IND_W16 = 6'h26;
  localparam logic [5:0] CICT_FAR_IND_W8 = 6'h36;
  localparam logic [5:0] CICT_WORD_MEM_ADD = 6'h04;
  localparam logic [5:0] CICT_CNT_RST = 6'h00;

  // Output clock low hold after reset release: two input clocks
  localparam int CICT_CLKIN_PERIOD_NS = 40;
  localparam int CICT_HOLD_NS = 2 * CICT_CLKIN_PERIOD_NS;
  localparam logic [1:0] CICT_HOLD_CYC = 2'(CICT_HOLD_NS / CICT_CLKIN_PERIOD_NS);

endpackage

// ### cict_core.sv
// Instruction cycle timing core with output clock alignment on reset release.
// Assumes all inputs except rst_n synchronous to clk; clk is the input clock.
`timescale 1ns/1ns

module cict_core (
  input wire logic clk, // Input clock, 25 MHz
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic ce, // Clock enable, freezes all state when low
  input wire logic resin_n, // Reset input pin, active low
  input wire logic bus8, // High for the 8-bit bus variant
  input wire logic req_valid, // Instruction request valid
  input wire cict_pkg::cict_req_t req, // Instruction request
  output logic req_ready, // Ready to take a request
  output logic busy, // Instruction in execution
  output logic done, // Last clock of the instruction
  output logic [5:0] cycles, // Clocks charged to current instruction
  output logic clkout // Output clock, half the input clock
);

  logic resin_q;
  logic clkout_q;
  logic [1:0] hold_q;
  logic busy_q;
  logic [5:0] cnt_q;
  logic [5:0] len_q;
  logic [5:0] len_d;
  logic [5:0] run_q;
  cict_pkg::cict_req_t cur_q;
  logic resin_rise;
  logic take;

  assign resin_rise = resin_n && !resin_q;
  assign req_ready = !busy_q && resin_n;
  assign take = ce && req_valid && req_ready;
  assign busy = busy_q;
  assign done = busy_q && (cnt_q == 6'h01);
  assign cycles = len_q;
  assign clkout = clkout_q;

  // Reset input edge detector; starts at idle high so no false edge after reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resin_q <= 1'b1;
    end else if (ce) begin
      resin_q <= resin_n;
    end
  end

  // Output clock divider with realignment on reset release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clkout_q <= 1'b0;
      hold_q <= 2'h0;
    end else if (ce) begin
      if (resin_rise && clkout_q) begin
        clkout_q <= 1'b0;
        hold_q <= cict_pkg::CICT_HOLD_CYC - 2'h1;
      end else if (hold_q != 2'h0) begin
        hold_q <= hold_q - 2'h1;
      end else begin
        clkout_q <= !clkout_q;
      end
    end
  end

  // Cycle figure lookup for a request
  always_comb begin
    len_d = cict_pkg::CICT_CNT_RST;
    unique case (req.op)
      cict_pkg::CICT_ADC_IMM_ACC, cict_pkg::CICT_CMP_IMM_ACC: begin
        len_d = req.second_form ? cict_pkg::CICT_ACC_WORD
                                : cict_pkg::CICT_ACC_BYTE;
      end
      cict_pkg::CICT_AND_RM_REG, cict_pkg::CICT_CMP_RM_REG: begin
        len_d = req.second_form ? cict_pkg::CICT_RM_MEM
                                : cict_pkg::CICT_RM_REG;
      end
      cict_pkg::CICT_ADC_IMM_RM: begin
        len_d = req.second_form ? cict_pkg::CICT_IMM_MEM : cict_pkg::CICT_IMM_REG;
      end
      cict_pkg::CICT_CALL_FAR_DIR: begin
        len_d = bus8 ? cict_pkg::CICT_FAR_DIR_W8 : cict_pkg::CICT_FAR_DIR_W16;
      end
      cict_pkg::CICT_CALL_NEAR_DIR: begin
        len_d = bus8 ? cict_pkg::CICT_NEAR_DIR_W8 : cict_pkg::CICT_NEAR_DIR_W16;
      end
      cict_pkg::CICT_CALL_FAR_IND: begin
        len_d = bus8 ? cict_pkg::CICT_FAR_IND_W8 : cict_pkg::CICT_FAR_IND_W16;
      end
    endcase
    // Word memory forms on the 8-bit bus pay for the extra transfer
    if (bus8 && req.word_op && req.second_form &&
        (req.op == cict_pkg::CICT_AND_RM_REG || req.op == cict_pkg::CICT_CMP_RM_REG ||
         req.op == cict_pkg::CICT_ADC_IMM_RM)) begin
      len_d = len_d + cict_pkg::CICT_WORD_MEM_ADD;
    end
  end

  // Execution counter; reset input aborts the running instruction
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      cnt_q <= cict_pkg::CICT_CNT_RST;
      len_q <= cict_pkg::CICT_CNT_RST;
      cur_q <= '0;
    end else if (ce) begin
      if (!resin_n) begin
        busy_q <= 1'b0;
        cnt_q <= cict_pkg::CICT_CNT_RST;
      end else if (take) begin
        busy_q <= 1'b1;
        cnt_q <= len_d;
        len_q <= len_d;
        cur_q <= req;
      end else if (busy_q) begin
        cnt_q <= cnt_q - 6'h01;
        busy_q <= (cnt_q != 6'h01);
      end
    end
  end

  // Helper: clocks spent so far by the running instruction
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_q <= 6'h00;
    end else if (ce) begin
      if (take) begin
        run_q <= 6'h00;
      end else if (busy_q) begin
        run_q <= run_q + 6'h01;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_rise_high;
    ce && resin_rise && clkout_q ##1 ce ##1 ce;
  endsequence

  sequence s_rise_low;
    ce && resin_rise && !clkout_q;
  endsequence

  a_clk_hold_low: assert property (
    s_rise_high |=> clkout_q && $past(!clkout_q) && $past(!clkout_q, 2))
    else $error("output clock not held low two clocks");

  a_clk_phase_kept: assert property (
    s_rise_low |=> clkout_q && hold_q == 2'h0)
    else $error("output clock disturbed on low phase release");

  a_adc_acc_len: assert property (
    ce && done && cur_q.op == cict_pkg::CICT_ADC_IMM_ACC |->
      run_q + 6'h01 == (cur_q.second_form ? 6'h04 : 6'h03))
    else $error("add with carry timing wrong");

  a_cmp_acc_len: assert property (
    ce && done && cur_q.op == cict_pkg::CICT_CMP_IMM_ACC |->
      run_q + 6'h01 == (cur_q.second_form ? 6'h04 : 6'h03))
    else $error("compare timing wrong");

  a_and_rm_len: assert property (
    ce && done && cur_q.op == cict_pkg::CICT_AND_RM_REG && !(bus8 && cur_q.word_op) |->
      run_q + 6'h01 == (cur_q.second_form ? 6'h0A : 6'h03))
    else $error("conjunction timing wrong");

  a_far_dir_len: assert property (
    ce && done && cur_q.op == cict_pkg::CICT_CALL_FAR_DIR |->
      run_q + 6'h01 == (bus8 ? 6'h1F : 6'h17))
    else $error("direct far call timing wrong");

  a_near_dir_len: assert property (
    ce && done && cur_q.op == cict_pkg::CICT_CALL_NEAR_DIR |->
      run_q + 6'h01 == (bus8 ? 6'h13 : 6'h0F))
    else $error("direct near call timing wrong");

  a_far_ind_len: assert property (
    ce && done && cur_q.op == cict_pkg::CICT_CALL_FAR_IND |->
      run_q + 6'h01 == (bus8 ? 6'h36 : 6'h26))
    else $error("indirect far call timing wrong");

  a_word_mem_add: assert property (
    ce && done && bus8 && cur_q.word_op && cur_q.second_form &&
      cur_q.op == cict_pkg::CICT_AND_RM_REG |-> run_q + 6'h01 == 6'h0E)
    else $error("word memory surcharge missing");

  a_pair_order: assert property (
    take && req.op == cict_pkg::CICT_CMP_RM_REG && !bus8 |=>
      len_q == (cur_q.second_form ? 6'h0A : 6'h03))
    else $error("paired figure order wrong");

endmodule

// ### tb_top.sv
// Bench for the instruction cycle timing core: timings and clock realign.
// Assumes a 25 MHz clock; inputs change 5 ns after the rising edge.
`timescale 1ns/1ns
module tb_top;
  logic clk, rst_n, ce, resin_n, bus8, req_valid, req_ready, busy, done, clkout, ce_rnd;
  logic [5:0] cycles;
  logic [31:0] rv;
  cict_pkg::cict_req_t req;
  int n_fail, total_checks, seed;

  cict_core u_cict_core (.clk(clk), .rst_n(rst_n), .ce(ce), .resin_n(resin_n), .bus8(bus8),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .busy(busy), .done(done),
    .cycles(cycles), .clkout(clkout));

  // Clock, 40 ns period
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Clock enable, stalls at random when asked
  always @(posedge clk) begin
    #5 ce = ce_rnd ? ($random(seed) % 4 != 0) : 1'b1;
  end

  // Expected clocks per instruction
  function automatic logic [5:0] exp_cyc(cict_pkg::cict_req_t r, logic b8);
    logic [5:0] sur;
    sur = (b8 && r.second_form && r.word_op) ? 6'h04 : 6'h00;
    case (r.op)
      cict_pkg::CICT_ADC_IMM_ACC, cict_pkg::CICT_CMP_IMM_ACC: begin
        exp_cyc = r.second_form ? 6'h04 : 6'h03;
      end
      cict_pkg::CICT_AND_RM_REG, cict_pkg::CICT_CMP_RM_REG: begin
        exp_cyc = (r.second_form ? 6'h0A : 6'h03) + sur;
      end
      cict_pkg::CICT_ADC_IMM_RM: exp_cyc = (r.second_form ? 6'h10 : 6'h04) + sur;
      cict_pkg::CICT_CALL_FAR_DIR: exp_cyc = b8 ? 6'h1F : 6'h17;
      cict_pkg::CICT_CALL_NEAR_DIR: exp_cyc = b8 ? 6'h13 : 6'h0F;
      default: exp_cyc = b8 ? 6'h36 : 6'h26;
    endcase
  endfunction

  task automatic chk_num(string what, logic [5:0] exp, logic [5:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic chk_bit(string what, logic exp, logic got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic conclude();
    if (n_fail == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Issue one request, hold it while busy, count enabled busy clocks
  task automatic run_req(cict_pkg::cict_req_t r, logic b8);
    logic [5:0] n;
    int k;
    n = 6'h01;
    k = 0;
    @(posedge clk);
    #5 req = r;
    bus8 = b8;
    req_valid = 1'b1;
    do begin
      @(negedge clk);
      k++;
    end while (busy !== 1'b1 && k < 50);
    chk_bit("take", 1'b1, busy);
    if (busy !== 1'b1) conclude();
    chk_num("cycles", exp_cyc(r, b8), cycles);
    k = 0;
    while (!(done === 1'b1 && ce) && k < 400) begin
      chk_bit("ready while busy", 1'b0, req_ready);
      chk_bit("done early", n == exp_cyc(r, b8), done);
      if (ce) n++;
      @(negedge clk);
      k++;
    end
    if (k >= 400) begin
      n_fail++;
      conclude();
    end
    chk_num("busy length", exp_cyc(r, b8), n);
    @(posedge clk);
    #5 req_valid = 1'b0;
    @(negedge clk);
    chk_bit("busy after done", 1'b0, busy);
  endtask

  // Abort by the reset input, then check clock realign on its release
  task automatic resync(int lo);
    logic v;
    @(posedge clk);
    #5 req = '{op: cict_pkg::CICT_CALL_FAR_DIR, second_form: 1'b0, word_op: 1'b0};
    req_valid = 1'b1;
    repeat (3) @(posedge clk);
    #5 resin_n = 1'b0;
    req_valid = 1'b0;
    @(negedge clk);
    chk_bit("ready in reset input", 1'b0, req_ready);
    @(negedge clk);
    chk_bit("busy abort", 1'b0, busy);
    repeat (lo) @(posedge clk);
    #5 resin_n = 1'b1;
    @(negedge clk);
    v = clkout;
    @(negedge clk);
    chk_bit("clkout first", !v, clkout);
    @(negedge clk);
    chk_bit("clkout second", 1'b0, clkout);
    @(negedge clk);
    chk_bit("clkout third", 1'b1, clkout);
  endtask

  // Main sequence
  initial begin
    seed = 78;
    n_fail = 0;
    total_checks = 0;
    ce_rnd = 1'b0;
    rst_n = 1'b0;
    resin_n = 1'b1;
    bus8 = 1'b0;
    req_valid = 1'b0;
    req = '0;
    repeat (3) @(posedge clk);
    #5 rst_n = 1'b1;
    for (int i = 0; i < 64; i++) begin
      rv = 32'(i);
      run_req(cict_pkg::cict_req_t'(rv[5:1]), rv[0]);
    end
    ce_rnd = 1'b1;
    for (int i = 0; i < 40; i++) begin
      rv = $random(seed);
      run_req(cict_pkg::cict_req_t'(rv[4:0]), rv[5]);
    end
    ce_rnd = 1'b0;
    // Random phase, then a release on the high phase, then one on the low phase
    resync(4);
    resync(5);
    resync(4);
    conclude();
  end
endmodule
